/* hw/pcq_irq_ctrl.v */
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pcq_consts.vh"

module pcq_irq_ctrl #(
	parameter ADR_W   = 12,
	parameter ALEN_W  = 4
) (
	// Clock and reset.
	input  wire              i_sys_clk,
	input  wire              i_reset_n,
	// Wishbone classic slave.
	input  wire              i_wb_cyc,
	input  wire              i_wb_stb,
	input  wire              i_wb_we,
	input  wire [ADR_W-1:0]  i_wb_adr,
	input  wire [3:0]        i_wb_sel,
	input  wire [31:0]       i_wb_dat,
	output wire [31:0]       o_wb_dat,
	output wire              o_wb_ack,
	// Interrupt sources.
	input  wire [31:0]       i_src_low,
	input  wire [31:0]       i_src_mid,
	input  wire              i_cpu_irq_in,
	input  wire              i_bus_error,
	input  wire              i_burst_valid,
	input  wire              i_burst_to_copro,
	input  wire [ALEN_W-1:0] i_burst_len,
	input  wire              i_vector_core0_halt,
	input  wire              i_vector_core1_halt,
	input  wire              i_doorbell0_event,
	input  wire              i_doorbell1_event,
	input  wire              i_mailbox0_request,
	input  wire              i_timer_event,
	// Per-core interrupt request lines.
	output wire [3:0]        o_core_irq
);

// ****************************************
// Helpers
// ****************************************
function [31:0] pcq_wmask;
	input [3:0] sel;
	begin
		pcq_wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	end
endfunction

// Pending local word of one core: masked local sources plus the two group summaries.
function [31:0] pcq_loc_pend;
	input [31:0] raw_loc;
	input [31:0] en_loc;
	input [31:0] pend_low;
	input [31:0] pend_mid;
	reg   [31:0] w;
	begin
		w = raw_loc & en_loc & `PCQ_LOC_EN_MASK; // [RULE1] [RULE2] [RULE19]
		w[`PCQ_BIT_SUM_MID] = |pend_mid; // [RULE3]
		w[`PCQ_BIT_SUM_LOW] = |pend_low; // [RULE4]
		pcq_loc_pend = w;
	end
endfunction

// ****************************************
// State
// ****************************************
reg  [31:0] en_low_ff [0:3];
reg  [31:0] en_mid_ff [0:3];
reg  [31:0] en_loc_ff [0:3];
reg  [7:0]  swtrig_ff;
reg         buserr_ff;
reg         burst_ff;
reg         bell0_ff;
reg         bell1_ff;
reg         timer_ff;
reg         cfg_halt_ff;
reg         ack_ff;
reg  [31:0] rdat_ff;
reg  [3:0]  irq_ff;
reg  [31:0] nxt_rdat;

wire [11:0] adr  = {i_wb_adr[11:2], 2'b00};
wire [1:0]  core = adr[7:6];
wire [5:0]  sub  = adr[5:0];
wire        in_core = (adr[11:8] == `PCQ_CORE_SLOT);
wire        req  = i_wb_cyc & i_wb_stb & ~ack_ff;
wire        wr   = req & i_wb_we;
wire        rd   = req & ~i_wb_we;
wire [31:0] wdat = i_wb_dat & pcq_wmask(i_wb_sel);

wire        halt0_eff = i_vector_core0_halt | (cfg_halt_ff & i_vector_core1_halt); // [RULE8]
wire [31:0] raw_loc = {i_cpu_irq_in, 15'h0000, swtrig_ff, buserr_ff, burst_ff,
	i_vector_core1_halt, halt0_eff, bell1_ff, bell0_ff, i_mailbox0_request, timer_ff}; // [RULE2] [RULE8] [RULE10]

wire        burst_hit = i_burst_valid & i_burst_to_copro & (i_burst_len != {ALEN_W{1'b0}}); // [RULE7]
wire        sw_set_wr = wr & (adr == `PCQ_SW_SET);
wire        sw_clr_wr = wr & (adr == `PCQ_SW_CLR);
wire        bell0_rd  = rd & (adr == `PCQ_BELL0);
wire        bell1_rd  = rd & (adr == `PCQ_BELL1);
wire        tmr_wr    = wr & (adr == `PCQ_TMR_CTRL);
wire        err_clr   = wr & (adr == `PCQ_ERR_CLR) & wdat[`PCQ_BIT_BURST];

// ****************************************
// Enable masks
// ****************************************
integer c;
always @(posedge i_sys_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		for (c = 0; c < 4; c = c + 1) begin
			en_low_ff[c] <= `PCQ_RST_WORD; // [RULE15]
			en_mid_ff[c] <= `PCQ_RST_WORD; // [RULE15]
			en_loc_ff[c] <= `PCQ_RST_WORD;
		end
	end else if (wr && in_core) begin
		case (sub)
			`PCQ_SUB_SET_LOW: en_low_ff[core] <= en_low_ff[core] | wdat; // [RULE11] [RULE18]
			`PCQ_SUB_SET_MID: en_mid_ff[core] <= en_mid_ff[core] | wdat; // [RULE11] [RULE18]
			`PCQ_SUB_SET_LOC: en_loc_ff[core] <= en_loc_ff[core] | (wdat & `PCQ_LOC_EN_MASK); // [RULE11] [RULE19]
			`PCQ_SUB_CLR_LOW: en_low_ff[core] <= en_low_ff[core] & ~wdat; // [RULE13] [RULE18]
			default: begin
			end
		endcase
	end
end

// ****************************************
// Local sticky sources
// ****************************************
// Every flag that hardware sets lets the set win over a clear in the same cycle.
always @(posedge i_sys_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		swtrig_ff   <= 8'h00;
		buserr_ff   <= 1'b0;
		burst_ff    <= 1'b0;
		bell0_ff    <= 1'b0;
		bell1_ff    <= 1'b0;
		timer_ff    <= 1'b0;
		cfg_halt_ff <= 1'b0;
	end else begin
		if (sw_set_wr) begin
			swtrig_ff <= swtrig_ff | wdat[7:0]; // [RULE5]
		end else if (sw_clr_wr) begin
			swtrig_ff <= swtrig_ff & ~wdat[7:0]; // [RULE5]
		end
		buserr_ff <= buserr_ff | i_bus_error; // [RULE6]
		burst_ff  <= burst_hit | (burst_ff & ~err_clr); // [RULE7]
		bell0_ff  <= i_doorbell0_event | (bell0_ff & ~bell0_rd); // [RULE9]
		bell1_ff  <= i_doorbell1_event | (bell1_ff & ~bell1_rd); // [RULE9]
		timer_ff  <= i_timer_event | (timer_ff & ~tmr_wr); // [RULE10]
		if (wr && adr == `PCQ_CFG) begin
			cfg_halt_ff <= wdat[`PCQ_CFG_HALT_BIT]; // [RULE8]
		end
	end
end

// ****************************************
// Read decode
// ****************************************
always @* begin
	nxt_rdat = 32'h00000000;
	if (in_core) begin
		case (sub)
			`PCQ_SUB_PEND_LOW: nxt_rdat = i_src_low & en_low_ff[core]; // [RULE1] [RULE16]
			`PCQ_SUB_PEND_MID: nxt_rdat = i_src_mid & en_mid_ff[core]; // [RULE1]
			`PCQ_SUB_PEND_LOC: nxt_rdat = pcq_loc_pend(raw_loc, en_loc_ff[core],
				i_src_low & en_low_ff[core], i_src_mid & en_mid_ff[core]);
			`PCQ_SUB_SET_LOW:  nxt_rdat = en_low_ff[core]; // [RULE12]
			`PCQ_SUB_SET_MID:  nxt_rdat = en_mid_ff[core]; // [RULE12]
			`PCQ_SUB_SET_LOC:  nxt_rdat = en_loc_ff[core]; // [RULE12]
			`PCQ_SUB_CLR_LOW:  nxt_rdat = en_low_ff[core]; // [RULE14]
			default: begin
				if (adr == `PCQ_RAW_LOW)
					nxt_rdat = i_src_low; // [RULE17]
				else if (adr == `PCQ_RAW_MID)
					nxt_rdat = i_src_mid; // [RULE17]
				else if (adr == `PCQ_RAW_LOC)
					nxt_rdat = raw_loc; // [RULE17]
			end
		endcase
	end else begin
		case (adr)
			`PCQ_SW_SET:  nxt_rdat = {24'h000000, swtrig_ff};
			`PCQ_SW_CLR:  nxt_rdat = {24'h000000, swtrig_ff};
			`PCQ_CFG:     nxt_rdat = {21'h000000, cfg_halt_ff, 10'h000};
			`PCQ_BELL0:   nxt_rdat = {31'h00000000, bell0_ff};
			`PCQ_BELL1:   nxt_rdat = {31'h00000000, bell1_ff};
			default:      nxt_rdat = 32'h00000000;
		endcase
	end
end

// ****************************************
// Bus answer and request lines
// ****************************************
// Registering the request lines costs one cycle but keeps them glitch free.
integer k;
always @(posedge i_sys_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		ack_ff  <= 1'b0;
		rdat_ff <= 32'h00000000;
		irq_ff  <= 4'h0;
	end else begin
		ack_ff <= req;
		if (rd) begin
			rdat_ff <= nxt_rdat;
		end
		for (k = 0; k < 4; k = k + 1) begin
			irq_ff[k] <= |pcq_loc_pend(raw_loc, en_loc_ff[k],
				i_src_low & en_low_ff[k], i_src_mid & en_mid_ff[k]); // [RULE1]
		end
	end
end

assign o_wb_ack   = ack_ff;
assign o_wb_dat   = rdat_ff;
assign o_core_irq = irq_ff;

endmodule

/* hw/pcq_consts.vh */
// Behaviour
// [RULE1] Per core, pending means active and enabled; all pending bits OR into the core's request.
// [RULE2] Local pending bit 31 follows the processor interrupt input.
// [RULE3] Local pending bit 25 is the OR of that core's pending sources 32 to 63.
// [RULE4] Local pending bit 24 is the OR of that core's pending sources 0 to 31.
// [RULE5] Bits 15:8 are software triggers, set and cleared only by their set/clear registers.
// [RULE6] Bit 7 latches a bus error and clears only on reset.
// [RULE7] Bit 6 rises on a burst access with nonzero length to coprocessor space.
// [RULE8] Bit 5 is vector core 1 halt; bit 4 core 0 halt, or core 1 if configured.
// [RULE9] Bits 3 and 2 are doorbell requests, cleared by reading the doorbell register.
// [RULE10] Bit 1 is mailbox 0; bit 0 is the timer, cleared by writing timer control.
// [RULE11] Writing one to a set-enable bit enables that source for that core.
// [RULE12] Reading a set-enable word returns the current enable mask.
// [RULE13] Writing one to a clear-enable bit disables that source for that core; the code has a clear-enable word only for sources 0 to 31.
// [RULE14] Reading a clear-enable word returns the same mask as its set-enable word.
// [RULE15] After reset all pending and enable bits for sources 0 to 63 read zero.
// [RULE16] Core 0 group starts with pending word at 0x200, then set-enable, then clear-enable.
// [RULE17] Raw source status before masking is readable separately.
// [RULE18] Writing zero to an enable bit leaves the mask bit unchanged.
// [RULE19] Reserved bits in pending and enable words read zero and ignore writes.
`ifndef PCQ_CONSTS_VH
`define PCQ_CONSTS_VH

// ****************************************
// Address map
// ****************************************
`define PCQ_CORE_SLOT      4'h2
`define PCQ_SUB_PEND_LOW   6'h00
`define PCQ_SUB_PEND_MID   6'h04
`define PCQ_SUB_PEND_LOC   6'h08
`define PCQ_SUB_SET_LOW    6'h10
`define PCQ_SUB_SET_MID    6'h14
`define PCQ_SUB_SET_LOC    6'h18
`define PCQ_SUB_CLR_LOW    6'h20
`define PCQ_RAW_LOW        12'h230
`define PCQ_RAW_MID        12'h234
`define PCQ_RAW_LOC        12'h238
`define PCQ_SW_SET         12'h3F0
`define PCQ_SW_CLR         12'h3F4
`define PCQ_CFG            12'h3F8
`define PCQ_ERR_CLR        12'h3FC
`define PCQ_BELL0          12'h400
`define PCQ_BELL1          12'h404
`define PCQ_TMR_CTRL       12'h408

// ****************************************
// Field layout and reset values
// ****************************************
`define PCQ_LOC_EN_MASK    32'h8000FFFF
`define PCQ_BIT_SUM_MID    25
`define PCQ_BIT_SUM_LOW    24
`define PCQ_BIT_BURST      6
`define PCQ_CFG_HALT_BIT   10
`define PCQ_RST_WORD       32'h00000000

`endif

/* verif/pcq_irq_ctrl_asserts.sv */
`timescale 1ns/1ps
module pcq_irq_ctrl_asserts (
	// Clock, reset and bus.
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	// Sources and requests.
	input wire logic [31:0] i_src_low,
	input wire logic [3:0]  o_core_irq
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	wire rd_ack = o_wb_ack && !i_wb_we;
	property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held too long");
	property p_ack_take; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
	a_ack_take: assert property (p_ack_take) else $error("request not answered");
	property p_irq_rst; $rose(i_reset_n) |-> o_core_irq == 4'h0; endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("request line high out of reset");
	property p_raw_low; rd_ack && i_wb_adr == 12'h230 && $stable(i_src_low) |-> o_wb_dat == i_src_low; endproperty
	a_raw_low: assert property (p_raw_low) else $error("raw status wrong");
	property p_unmap; rd_ack && i_wb_adr == 12'h100 |-> o_wb_dat == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_loc_rsvd;
		rd_ack && i_wb_adr[11:8] == 4'h2 && i_wb_adr[5:0] == 6'h08 |-> o_wb_dat[30:26] == 5'h0 && o_wb_dat[23:16] == 8'h0;
	endproperty
	a_loc_rsvd: assert property (p_loc_rsvd) else $error("reserved local bits set");
	property p_wr_hold; o_wb_ack && i_wb_we |-> $stable(o_wb_dat); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("read data moved on write");
	property p_rd_hold; $fell(o_wb_ack) |-> $stable(o_wb_dat); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
	c_loc: cover property (rd_ack && i_wb_adr == 12'h208);
	c_irq: cover property (o_core_irq != 4'h0);
	c_wr: cover property (o_wb_ack && i_wb_we);
endmodule
bind pcq_irq_ctrl pcq_irq_ctrl_asserts u_chk (.i_sys_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
	.o_wb_dat, .o_wb_ack, .i_src_low, .o_core_irq);

/* verif/pcq_wb_host.sv */
`timescale 1ns/1ps
module pcq_wb_host (
	// Clock and answer.
	input  wire logic        i_sys_clk,
	input  wire logic        i_ack,
	// Request.
	output logic             o_cyc,
	output logic             o_we,
	output logic [11:0]      o_adr,
	output logic [3:0]       o_sel,
	output logic [31:0]      o_dat
);
	initial {o_cyc, o_we, o_adr, o_sel, o_dat} = {2'h0, 12'h000, 4'hF, 32'h00000000};
	// Ack is sampled at the rising edge itself, so the request is released only after the answering edge.
	task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		{o_cyc, o_we, o_adr, o_dat} <= {1'b1, we, a, d};
		do @(posedge i_sys_clk); while (i_ack !== 1'b1);
		{o_cyc, o_adr, o_dat} <= {1'b0, ~a, ~d};
	endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "pcq_consts.vh"
module testbench;
	logic        i_sys_clk = 0, i_reset_n = 0, i_cpu_irq_in = 0, i_bus_error = 0, i_burst_valid = 0;
	logic        i_burst_to_copro = 0, i_vector_core0_halt = 0, i_vector_core1_halt = 0, i_doorbell0_event = 0;
	logic        i_doorbell1_event = 0, i_mailbox0_request = 0, i_timer_event = 0, i_wb_cyc, i_wb_we, o_wb_ack;
	logic [3:0]  i_burst_len = 0, i_wb_sel, o_core_irq;
	logic [11:0] i_wb_adr, b;
	logic [31:0] i_src_low = 0, i_src_mid = 0, i_wb_dat, o_wb_dat, x, f, eo[4], em[4], el[4];
	logic [31:0] q[$];
	int          n_fail = 0, num_checks = 0;
	pcq_irq_ctrl dut (.i_sys_clk, .i_reset_n, .i_wb_cyc, .i_wb_stb(i_wb_cyc), .i_wb_we, .i_wb_adr, .i_wb_sel,
		.i_wb_dat, .o_wb_dat, .o_wb_ack, .i_src_low, .i_src_mid, .i_cpu_irq_in, .i_bus_error, .i_burst_valid,
		.i_burst_to_copro, .i_burst_len, .i_vector_core0_halt, .i_vector_core1_halt, .i_doorbell0_event,
		.i_doorbell1_event, .i_mailbox0_request, .i_timer_event, .o_core_irq);
	pcq_wb_host host (.i_sys_clk, .i_ack(o_wb_ack), .o_cyc(i_wb_cyc), .o_we(i_wb_we), .o_adr(i_wb_adr),
		.o_sel(i_wb_sel), .o_dat(i_wb_dat));
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		host.xfer(1'b0, a, 32'h0);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d);
	endtask
	function logic [31:0] pl(int c);
		pl = f & el[c] & `PCQ_LOC_EN_MASK;
		pl[25] = |(i_src_mid & em[c]);
		pl[24] = |(i_src_low & eo[c]);
	endfunction
	task irqs;
		repeat (2) @(posedge i_sys_clk);
		for (int c = 0; c < 4; c++) chk({31'h0, o_core_irq[c]}, {31'h0, |pl(c)});
	endtask
	task summarize;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_sys_clk) if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) chk(o_wb_dat, q.pop_front());
	initial begin
		#30us;
		n_fail++;
		summarize;
	end
	// ********************************
	// Main sequence
	// ********************************
	initial begin
		x = $urandom(58056);
		f = 32'h0;
		for (int c = 0; c < 4; c++) {eo[c], em[c], el[c]} = 96'h0;
		repeat (6) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		foreach (eo[c]) for (int k = 0; k < 9; k++) if (k != 3 && k < 7 || k == 8) rd(12'h200 + 12'(c * 64 + k * 4), 0);
		i_src_low <= $urandom;
		i_src_mid <= $urandom;
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			b = 12'h200 + 12'(c * 64);
			eo[c] = $urandom;
			em[c] = $urandom;
			x = $urandom;
			wr(b + 12'h10, eo[c]);
			wr(b + 12'h14, em[c]);
			wr(b + 12'h20, x);
			eo[c] &= ~x;
			rd(b, i_src_low & eo[c]);
			rd(b + 12'h04, i_src_mid & em[c]);
			rd(b + 12'h10, eo[c]);
			rd(b + 12'h20, eo[c]);
			rd(b + 12'h08, pl(c));
			irqs;
		end
		$display("test masks done");
		wr(12'h218, 32'hFFFFFFFF);
		el[0] = `PCQ_LOC_EN_MASK;
		rd(12'h218, el[0]);
		wr(`PCQ_SW_SET, 32'hA5);
		wr(`PCQ_SW_CLR, 32'h05);
		{i_burst_valid, i_burst_to_copro, i_bus_error, i_doorbell0_event, i_doorbell1_event, i_timer_event} <= 6'h3F;
		{i_vector_core1_halt, i_mailbox0_request, i_cpu_irq_in} <= 3'h7;
		@(posedge i_sys_clk);
		{i_bus_error, i_doorbell0_event, i_doorbell1_event, i_timer_event} <= 4'h0;
		f = 32'h8000A0AF;
		rd(12'h208, pl(0));
		i_burst_len <= 4'h1 + 4'($urandom % 15);
		wr(`PCQ_CFG, 32'h400);
		f[6] = 1'b1;
		f[4] = 1'b1;
		rd(12'h208, pl(0));
		irqs;
		rd(`PCQ_BELL0, 32'h1);
		rd(`PCQ_BELL1, 32'h1);
		wr(`PCQ_TMR_CTRL, 32'h0);
		wr(`PCQ_SW_CLR, 32'hFF);
		f = f & 32'hFFFF00F2;
		rd(12'h208, pl(0));
		rd(12'h100, 32'h0);
		irqs;
		rd(`PCQ_RAW_LOW, i_src_low);
		rd(`PCQ_RAW_MID, i_src_mid);
		rd(`PCQ_RAW_LOC, f);
		i_burst_valid <= 1'b0;
		wr(`PCQ_ERR_CLR, 32'h40);
		f[6] = 1'b0;
		rd(12'h208, pl(0));
		$display("test local done");
		i_reset_n <= 1'b0;
		@(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		for (int c = 0; c < 4; c++) {eo[c], em[c], el[c]} = 96'h0;
		rd(`PCQ_RAW_LOC, 32'h80000022);
		rd(12'h208, 32'h0);
		irqs;
		$display("test reset again done");
		summarize;
	end
endmodule
